// ===== sdp_pkg.sv
// Shared constants and types for the synchronous DRAM pin front end
//==============================================================
// Summary of operation
// - Row uses twelve address bits, column nine
// - Address bit ten selects precharge of all banks
// - Bank select captured with row or column
// - Chip select high ignores commands, work continues
// - Row, column, write strobes decode the command
// - Read byte mask floats data two cycles later
// - Write byte mask blocks that byte immediately
// - All inputs but arst_n sampled on rising clock edge only
// - Clock enable low: power-down, suspend or self-refresh
// - One bidirectional sixteen-bit data bus
// - All strobes low sets mode from address
// - Each byte mask governs its own lane
package sdp_pkg;
   //==============================================================
   // Pin geometry
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int DQ_W = 16;
   localparam int LANES = 2;
   localparam int ALL_BANKS_BIT = 10;
   localparam int AUTO_PRE_BIT = 10;
   //==============================================================
   // Mode register layout
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam logic [ROW_W-1:0] MR_RESET = 12'h000;
   localparam logic [2:0] BL_CODE_1 = 3'h0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_PAGE = 3'h7;
   localparam logic [2:0] CL_CODE_2 = 3'h2;
   localparam logic [COL_W:0] PAGE_LEN = 10'h200;
   //==============================================================
   // Storage window and init bookkeeping
   localparam int MEM_IDX_W = 8;
   localparam int MEM_WORDS = 256;
   localparam int ROW_IDX_BITS = 2;
   localparam int COL_IDX_BITS = 4;
   localparam int FIFO_DEPTH = 32;
   localparam int PUSH_W = MEM_IDX_W + DQ_W + LANES;
   localparam logic [3:0] INIT_REFRESH = 4'h8;
   //==============================================================
   typedef enum logic [3:0] {
      CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
      CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET
   } sdp_cmd_t;
   typedef enum logic [1:0] {
      PWR_ACTIVE, PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH
   } sdp_pwr_t;
endpackage : sdp_pkg

// ===== sdp_cmd_decode.sv
// Command decoder for the chip select and three strobe pins
`timescale 1ns/100ps
module sdp_cmd_decode (
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   output sdp_pkg::sdp_cmd_t cmd
);
   import sdp_pkg::*;
   always_comb begin
      cmd = CMD_NOP;
      if (csN) begin
         cmd = CMD_DESELECT;
      end else begin
         unique case ({rasN, casN, weN})
            3'h7: cmd = CMD_NOP;
            3'h3: cmd = CMD_ACTIVATE;
            3'h5: cmd = CMD_READ;
            3'h4: cmd = CMD_WRITE;
            3'h6: cmd = CMD_BURST_STOP;
            3'h2: cmd = CMD_PRECHARGE;
            3'h1: cmd = CMD_REFRESH;
            3'h0: cmd = CMD_MODE_SET;
         endcase
      end
   end
endmodule : sdp_cmd_decode

// ===== sdp_fifo.sv
// Write-data buffer with valid and ready on both sides
`timescale 1ns/100ps
module sdp_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic [AW:0] count_d;
   logic notFull_q;
   logic push;
   logic pop;

   assign push = inValid && notFull_q;
   assign pop = outValid && outReady;
   assign inReady = notFull_q;
   assign outValid = (count_q != '0);
   assign outData = mem_q[rdPtr_q];
   assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         notFull_q <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         count_q <= count_d;
         // Registered so the ready seen by the source never depends on the sink in the same cycle
         notFull_q <= (count_d != (AW+1)'(DEPTH));
      end
   end
endmodule : sdp_fifo

// ===== sdp_pin_front.sv
// Synchronous DRAM pin front end: command decode, banks, mode, bursts, data pins
`timescale 1ns/100ps
module sdp_pin_front (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [sdp_pkg::ROW_W-1:0] addr,
   input wire logic bank_select_bit_zero,
   input wire logic bank_select_bit_one,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   input wire logic [sdp_pkg::DQ_W-1:0] dqIn,
   output logic [sdp_pkg::DQ_W-1:0] dqOut_q,
   output logic [sdp_pkg::DQ_W-1:0] dqOe_q,
   input wire logic dropClear,
   output logic writeDrop_q,
   output logic bufferReady,
   output logic [sdp_pkg::ROW_W-1:0] modeReg_q,
   output logic modeValid_q,
   output sdp_pkg::sdp_pwr_t powerState_q,
   output logic [sdp_pkg::NUM_BANKS-1:0] bankOpen_q,
   output logic [3:0] refreshCount_q,
   output logic initDone_q
);
   import sdp_pkg::*;

   //==============================================================
   // Command decode
   sdp_cmd_t cmd;
   logic clkEn;
   logic acc;
   logic [BANK_W-1:0] bankSel;
   logic [LANES-1:0] mask;

   sdp_cmd_decode uDecode (
      .csN(csN),
      .rasN(rasN),
      .casN(casN),
      .weN(weN),
      .cmd(cmd)
   );

   assign bankSel = {bank_select_bit_one, bank_select_bit_zero};
   assign mask = {upper_byte_mask, lower_byte_mask};
   assign clkEn = cke;
   // Deselect and gated clock both leave running work untouched
   assign acc = clkEn && (cmd != CMD_DESELECT);

   //==============================================================
   // Bank rows and open flags
   logic [ROW_W-1:0] row_q [NUM_BANKS];
   logic burstEnd;
   logic newRw;
   logic [BANK_W-1:0] curBank;
   logic autoPre_q;
   logic [BANK_W-1:0] burstBank_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bankOpen_q <= '0;
         for (int b = 0; b < NUM_BANKS; b++) begin
            row_q[b] <= '0;
         end
      end else begin
         // A one-word burst ends on its own command edge, so take the flag live
         if (burstEnd && (newRw ? addr[AUTO_PRE_BIT] : autoPre_q)) begin
            bankOpen_q[curBank] <= 1'b0;
         end
         if (acc && cmd == CMD_ACTIVATE) begin
            row_q[bankSel] <= addr;
            bankOpen_q[bankSel] <= 1'b1;
         end else if (acc && cmd == CMD_PRECHARGE) begin
            if (addr[ALL_BANKS_BIT]) begin
               bankOpen_q <= '0;
            end else begin
               bankOpen_q[bankSel] <= 1'b0;
            end
         end
      end
   end

   //==============================================================
   // Mode register and init bookkeeping
   logic preAllSeen_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         modeReg_q <= MR_RESET;
         modeValid_q <= 1'b0;
      end else if (acc && cmd == CMD_MODE_SET) begin
         modeReg_q <= addr;
         modeValid_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         preAllSeen_q <= 1'b0;
         refreshCount_q <= '0;
         initDone_q <= 1'b0;
      end else begin
         if (acc && cmd == CMD_PRECHARGE && addr[ALL_BANKS_BIT]) begin
            preAllSeen_q <= 1'b1;
         end
         if (acc && cmd == CMD_REFRESH && refreshCount_q != INIT_REFRESH) begin
            refreshCount_q <= refreshCount_q + 4'h1;
         end
         initDone_q <= preAllSeen_q && modeValid_q && (refreshCount_q == INIT_REFRESH);
      end
   end

   //==============================================================
   // Power states entered while clock enable is low
   logic burstActive_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         powerState_q <= PWR_ACTIVE;
      end else if (cke) begin
         powerState_q <= PWR_ACTIVE;
      end else if (powerState_q == PWR_ACTIVE) begin
         if (cmd == CMD_REFRESH) begin
            powerState_q <= PWR_SELF_REFRESH;
         end else if (burstActive_q) begin
            powerState_q <= PWR_SUSPEND;
         end else begin
            powerState_q <= PWR_DOWN;
         end
      end
   end

   //==============================================================
   // Burst sequencing
   logic [COL_W-1:0] startCol_q;
   logic [COL_W-1:0] idx_q;
   logic burstWrite_q;
   logic stopNow;
   logic curActive;
   logic curWrite;
   logic [COL_W-1:0] curStart;
   logic [COL_W-1:0] curIdx;
   logic [COL_W-1:0] curCol;
   logic [COL_W-1:0] lenMask;
   logic [COL_W:0] blLen;
   logic [COL_W:0] nextIdx;
   logic [MEM_IDX_W-1:0] memIdx;
   logic [ROW_W-1:0] curRow;

   always_comb begin
      unique case (modeReg_q[MR_BL_LSB +: 3])
         BL_CODE_2: blLen = 10'h002;
         BL_CODE_4: blLen = 10'h004;
         BL_CODE_8: blLen = 10'h008;
         BL_CODE_PAGE: blLen = PAGE_LEN;
         default: blLen = 10'h001;
      endcase
   end

   assign lenMask = COL_W'(blLen - 10'h001);
   assign newRw = acc && (cmd == CMD_READ || cmd == CMD_WRITE);
   // A burst stop or a precharge of the bank in use ends the burst at once
   assign stopNow = acc && (cmd == CMD_BURST_STOP ||
      (cmd == CMD_PRECHARGE && (addr[ALL_BANKS_BIT] || bankSel == burstBank_q)));
   assign curActive = clkEn && (newRw || (burstActive_q && !stopNow));
   assign curWrite = newRw ? (cmd == CMD_WRITE) : burstWrite_q;
   assign curBank = newRw ? bankSel : burstBank_q;
   assign curStart = newRw ? addr[COL_W-1:0] : startCol_q;
   assign curIdx = newRw ? '0 : idx_q;
   assign curCol = modeReg_q[MR_BT_BIT] ? (curStart ^ curIdx) :
      ((curStart & ~lenMask) | ((curStart + curIdx) & lenMask));
   assign nextIdx = {1'b0, curIdx} + 10'h001;
   assign burstEnd = curActive && (nextIdx == blLen);
   assign curRow = row_q[curBank];
   assign memIdx = {curBank, curRow[ROW_IDX_BITS-1:0], curCol[COL_IDX_BITS-1:0]};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         burstActive_q <= 1'b0;
         burstWrite_q <= 1'b0;
         burstBank_q <= '0;
         startCol_q <= '0;
         idx_q <= '0;
         autoPre_q <= 1'b0;
      end else if (clkEn) begin
         if (newRw) begin
            burstWrite_q <= (cmd == CMD_WRITE);
            burstBank_q <= bankSel;
            startCol_q <= addr[COL_W-1:0];
            autoPre_q <= addr[AUTO_PRE_BIT];
         end
         burstActive_q <= curActive && !burstEnd;
         idx_q <= nextIdx[COL_W-1:0];
      end
   end

   //==============================================================
   // Write path through the buffer; masked lanes never reach storage
   logic [DQ_W-1:0] memWord;
   logic pushValid;
   logic pushReady;
   logic [LANES-1:0] pushBe;
   logic popValid;
   logic popReady;
   logic [PUSH_W-1:0] popData;
   logic readFetch;
   logic [MEM_IDX_W-1:0] popIdx;
   logic [DQ_W-1:0] popWord;
   logic [LANES-1:0] popBe;

   assign pushBe = ~mask;
   assign pushValid = curActive && curWrite && (pushBe != '0);
   assign readFetch = curActive && !curWrite;
   // Single storage port: a read fetch stalls draining, so the buffer can fill
   assign popReady = !readFetch;
   assign {popIdx, popWord, popBe} = popData;
   assign bufferReady = pushReady;

   sdp_fifo #(
      .WIDTH(PUSH_W),
      .DEPTH(FIFO_DEPTH)
   ) uFifo (
      .clock(clock),
      .arst_n(arst_n),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData({memIdx, dqIn, pushBe}),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popData)
   );

   for (genvar l = 0; l < LANES; l++) begin : gLane
      logic [7:0] laneMem_q [MEM_WORDS];
      always_ff @(posedge clock) begin
         if (popValid && popReady && popBe[l]) begin
            laneMem_q[popIdx] <= popWord[8*l +: 8];
         end
      end
      assign memWord[8*l +: 8] = laneMem_q[memIdx];
   end

   // Buffer overflow loses the word; the sticky flag tells software
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         writeDrop_q <= 1'b0;
      end else if (pushValid && !pushReady) begin
         writeDrop_q <= 1'b1;
      end else if (dropClear) begin
         writeDrop_q <= 1'b0;
      end
   end

   //==============================================================
   // Read path: latency from the mode register, masks act two edges on
   logic [DQ_W-1:0] p1_q;
   logic [DQ_W-1:0] p2_q;
   logic p1Valid_q;
   logic p2Valid_q;
   logic [LANES-1:0] maskD1_q;
   logic casLat2;
   logic srcValid;
   logic [DQ_W-1:0] srcWord;

   assign casLat2 = (modeReg_q[MR_CL_LSB +: 3] == CL_CODE_2);
   assign srcValid = casLat2 ? p1Valid_q : p2Valid_q;
   assign srcWord = casLat2 ? p1_q : p2_q;

   // Clock suspend freezes the whole pipe, output drivers included
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         p1_q <= '0;
         p2_q <= '0;
         p1Valid_q <= 1'b0;
         p2Valid_q <= 1'b0;
         maskD1_q <= '1;
         dqOut_q <= '0;
         dqOe_q <= '0;
      end else if (clkEn) begin
         p1_q <= memWord;
         p1Valid_q <= readFetch;
         p2_q <= p1_q;
         p2Valid_q <= p1Valid_q;
         maskD1_q <= mask;
         dqOut_q <= srcWord;
         for (int l = 0; l < LANES; l++) begin
            dqOe_q[8*l +: 8] <= {8{srcValid && !maskD1_q[l]}};
         end
      end
   end

   //==============================================================
   // Checks
   chk_mask_read_hiz: assert property (@(posedge clock) disable iff (!arst_n)
      (upper_byte_mask && cke) ##1 cke |-> ##1 !dqOe_q[DQ_W-1])
      else $error("upper lane still driven two edges after mask");
   chk_write_mask_lane: assert property (@(posedge clock) disable iff (!arst_n)
      (curActive && curWrite && lower_byte_mask) |-> (!pushValid || !pushBe[0]))
      else $error("masked lower byte pushed toward storage");
   chk_write_both_masked: assert property (@(posedge clock) disable iff (!arst_n)
      (acc && cmd == CMD_WRITE && mask == 2'h3) |-> !pushValid)
      else $error("fully masked write word was pushed");
   chk_deselect_mode_hold: assert property (@(posedge clock) disable iff (!arst_n)
      csN |=> $stable(modeReg_q) && $stable(modeValid_q))
      else $error("mode changed while chip deselected");
   chk_mode_set_load: assert property (@(posedge clock) disable iff (!arst_n)
      (cke && !csN && !rasN && !casN && !weN) |=> modeReg_q == $past(addr) && modeValid_q)
      else $error("mode set did not load address");
   chk_activate_row: assert property (@(posedge clock) disable iff (!arst_n)
      (cke && !csN && !rasN && casN && weN) |=>
      row_q[$past(bankSel)] == $past(addr) && bankOpen_q[$past(bankSel)])
      else $error("activate did not open row in selected bank");
   chk_precharge_all: assert property (@(posedge clock) disable iff (!arst_n)
      (acc && cmd == CMD_PRECHARGE && addr[ALL_BANKS_BIT]) |=> bankOpen_q == '0)
      else $error("precharge all left a bank open");
   chk_cke_freeze: assert property (@(posedge clock) disable iff (!arst_n)
      !cke |=> $stable(idx_q) && $stable(dqOe_q) && powerState_q != PWR_ACTIVE)
      else $error("internal clock ran with enable low");
   chk_read_latency: assert property (@(posedge clock) disable iff (!arst_n)
      (acc && cmd == CMD_READ && casLat2 && !lower_byte_mask) ##1
      (cke && !lower_byte_mask) |-> ##1 dqOe_q[0])
      else $error("read data not driven at latency two");

   cov_read: cover property (@(posedge clock) disable iff (!arst_n)
      (acc && cmd == CMD_READ) ##[1:4] dqOe_q[0]);
   cov_write: cover property (@(posedge clock) disable iff (!arst_n)
      pushValid ##1 popValid);
   cov_self_refresh: cover property (@(posedge clock) disable iff (!arst_n)
      powerState_q == PWR_SELF_REFRESH);
   cov_init_done: cover property (@(posedge clock) disable iff (!arst_n)
      $rose(initDone_q));
endmodule : sdp_pin_front

// ===== sdp_host_model.sv
// Host controller model: command pins, byte masks, write data and the power-up sequence
`timescale 1ns/100ps
module sdp_host_model #(
   parameter int CLK_NS = 4,
   parameter int PAUSE_NS = 200000
) (
   input wire logic clock,
   output logic cke,
   output logic csN,
   output logic rasN,
   output logic casN,
   output logic weN,
   output logic [sdp_pkg::ROW_W-1:0] addr,
   output logic bankSelectBitZero,
   output logic bankSelectBitOne,
   output logic upperByteMask,
   output logic lowerByteMask,
   output logic [sdp_pkg::DQ_W-1:0] hostDq
);
   import sdp_pkg::*;
   // Rounded up so the pause is never short of the required time
   localparam int PAUSE_CYCLES = (PAUSE_NS + CLK_NS - 1) / CLK_NS;
   //==============================================================
   // Pin driver
   initial begin
      cke = 1'b1;
      {csN, rasN, casN, weN} = 4'h7;
      addr = 12'h000;
      {bankSelectBitOne, bankSelectBitZero} = 2'h0;
      {upperByteMask, lowerByteMask} = 2'h3;
      hostDq = 16'h5a5a;
   end
   // One command per edge; pins change just after the edge and hold a full cycle
   task automatic drive(input logic en, input logic [3:0] code, input logic [1:0] bank,
         input logic [11:0] a, input logic [1:0] mask, input logic [15:0] d);
      @(posedge clock);
      #1;
      cke = en;
      {csN, rasN, casN, weN} = code;
      {bankSelectBitOne, bankSelectBitZero} = bank;
      addr = a;
      {upperByteMask, lowerByteMask} = mask;
      hostDq = d;
   endtask : drive
   //==============================================================
   // Power-up sequence; idle data lines toggle so a stale value never looks valid
   task automatic init_seq(input logic [11:0] mode);
      repeat (PAUSE_CYCLES) drive(1'b1, 4'h7, 2'h0, 12'h000, 2'h3, ~hostDq);
      drive(1'b1, 4'h2, 2'h0, 12'h400, 2'h3, ~hostDq);
      drive(1'b1, 4'h7, 2'h0, 12'h000, 2'h3, ~hostDq);
      drive(1'b1, 4'h0, 2'h0, mode, 2'h3, ~hostDq);
      repeat (8) begin
         drive(1'b1, 4'h1, 2'h0, 12'h000, 2'h3, ~hostDq);
         drive(1'b1, 4'h7, 2'h0, 12'h000, 2'h3, ~hostDq);
      end
   endtask : init_seq
endmodule : sdp_host_model

// ===== tb_sdram_pin_protocol_and_power_up_init.sv
// Self-checking bench for the synchronous DRAM pin front end
`timescale 1ns/100ps
module tb_sdram_pin_protocol_and_power_up_init;
   import sdp_pkg::*;
   typedef struct {logic [15:0] data; logic [15:0] oe; int cyc;} sdp_rd_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic cke, csN, rasN, casN, weN, bankSelectBitZero, bankSelectBitOne;
   logic upperByteMask, lowerByteMask, modeValid, initDone, bufferReady, writeDrop;
   logic [11:0] addr, modeReg;
   logic [15:0] hostDq, dqOut, dqOe, dqBus, seed = 16'h7615;
   logic [3:0] bankOpen, refreshCount;
   sdp_pwr_t powerState;
   logic [15:0] mem [256];
   logic [11:0] rowOf [4];
   sdp_rd_t expQ[$];
   int cyc = 0, badCount = 0, nCompared = 0;
   always #2 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   // Released lanes show the host's toggling pattern, never the last read word
   assign dqBus = (dqOe & dqOut) | (~dqOe & hostDq);
   sdp_host_model i_host (.clock(clock), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .addr(addr), .bankSelectBitZero(bankSelectBitZero),
      .bankSelectBitOne(bankSelectBitOne), .upperByteMask(upperByteMask),
      .lowerByteMask(lowerByteMask), .hostDq(hostDq));
   sdp_pin_front i_dut (.clock(clock), .arst_n(arst_n), .cke(cke), .csN(csN), .rasN(rasN),
      .casN(casN), .weN(weN), .addr(addr), .bank_select_bit_zero(bankSelectBitZero),
      .bank_select_bit_one(bankSelectBitOne), .upper_byte_mask(upperByteMask),
      .lower_byte_mask(lowerByteMask), .dqIn(dqBus), .dqOut_q(dqOut), .dqOe_q(dqOe),
      .dropClear(1'b0), .writeDrop_q(writeDrop), .bufferReady(bufferReady), .modeReg_q(modeReg),
      .modeValid_q(modeValid), .powerState_q(powerState), .bankOpen_q(bankOpen),
      .refreshCount_q(refreshCount), .initDone_q(initDone));
   //==============================================================
   // Reporting
   task automatic complete_run_msg;
      $display("compared %0d mismatches %0d", nCompared, badCount);
   endtask : complete_run_msg
   task automatic completeRun;
      complete_run_msg();
      if (badCount == 0 && nCompared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : completeRun
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_read(input logic [47:0] got, input sdp_rd_t e);
      logic [47:0] exp;
      exp = {e.cyc[15:0], e.oe, e.data & e.oe};
      nCompared++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_read
   //==============================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [3:0] bcol(input logic [3:0] c, input int i, input int bl,
         input logic il);
      logic [3:0] m;
      m = 4'(bl - 1);
      if (il) return c ^ 4'(i);
      return (c & ~m) | ((c + 4'(i)) & m);
   endfunction : bcol
   task automatic cmd(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a);
      i_host.drive(1'b1, code, b, a, 2'h0, ~hostDq);
   endtask : cmd
   task automatic nop(input int n);
      repeat (n) cmd(4'h7, 2'h0, 12'h000);
   endtask : nop
   task automatic act(input logic [1:0] b, input logic [11:0] r);
      cmd(4'h3, b, r);
      rowOf[b] = r;
   endtask : act
   task automatic wr(input logic [1:0] b, input logic [3:0] col, input int mw,
         input logic [1:0] mv);
      logic [15:0] d;
      logic [1:0] m;
      logic [7:0] idx;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         d = seed;
         m = (i == mw) ? mv : 2'h0;
         idx = {b, rowOf[b][1:0], bcol(col, i, 4, 1'b0)};
         if (!m[0]) mem[idx][7:0] = d[7:0];
         if (!m[1]) mem[idx][15:8] = d[15:8];
         i_host.drive(1'b1, (i == 0) ? 4'h4 : 4'h7, b, {8'h00, col}, m, d);
      end
   endtask : wr
   // Mask in cycle j reaches the word leaving at edge j+1 after the command
   task automatic rd(input logic [1:0] b, input logic [3:0] col, input int cl, input logic il,
         input int mw, input logic [1:0] mv);
      sdp_rd_t e;
      int k;
      for (int j = 0; j < cl + 4; j++) begin
         i_host.drive(1'b1, (j == 0) ? 4'h5 : 4'h7, b, {8'h00, col},
            (j == mw + cl - 2) ? mv : 2'h0, ~hostDq);
         if (j == 0) begin
            k = cyc + 1;
            for (int i = 0; i < 4; i++) begin
               e.data = mem[{b, rowOf[b][1:0], bcol(col, i, 4, il)}];
               e.oe = (i == mw) ? {{8{~mv[1]}}, {8{~mv[0]}}} : 16'hffff;
               e.cyc = k + cl - 1 + i;
               // A fully masked word never drives, so no note can be taken for it
               if (e.oe != 16'h0) expQ.push_back(e);
            end
         end
      end
   endtask : rd
   //==============================================================
   // Read watcher: every driven word must match the oldest note
   always @(negedge clock) begin
      if (arst_n && (|dqOe)) begin
         if (expQ.size() == 0) check_val(32'(dqOe), 32'h0);
         else check_read({cyc[15:0], dqOe, dqOut & dqOe}, expQ.pop_front());
      end
   end
   initial begin
      repeat (60000) @(posedge clock);
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, cyc, 32'h0);
      completeRun();
   end
   //==============================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      #1;
      check_val({bankOpen, modeValid, initDone, bufferReady, refreshCount, powerState},
         {4'h0, 1'b0, 1'b0, 1'b1, 4'h0, PWR_ACTIVE});
      arst_n = 1'b1;
      i_host.init_seq(12'h022);
      nop(2);
      check_val({modeReg, modeValid, refreshCount, initDone}, {12'h022, 1'b1, 4'h8, 1'b1});
      act(2'h1, 12'h5a7);
      cmd(4'hb, 2'h2, 12'h0f0);
      act(2'h0, 12'h003);
      nop(1);
      check_val(32'(bankOpen), 32'h3);
      wr(2'h1, 4'h0, 9, 2'h0);
      wr(2'h1, 4'h0, 2, 2'h1);
      wr(2'h0, 4'h8, 9, 2'h0);
      wr(2'h0, 4'h8, 1, 2'h2);
      nop(40);
      rd(2'h1, 4'h1, 2, 1'b0, 1, 2'h2);
      rd(2'h0, 4'h9, 2, 1'b0, 3, 2'h1);
      cmd(4'h2, 2'h0, 12'h000);
      nop(1);
      check_val(32'(bankOpen), 32'h2);
      cmd(4'h2, 2'h3, 12'h400);
      nop(1);
      check_val(32'(bankOpen), 32'h0);
      cmd(4'h0, 2'h0, 12'h03a);
      nop(1);
      act(2'h1, 12'h5a7);
      act(2'h0, 12'h003);
      rd(2'h1, 4'h1, 3, 1'b1, 0, 2'h1);
      rd(2'h0, 4'ha, 3, 1'b1, 2, 2'h3);
      cmd(4'h2, 2'h0, 12'h400);
      nop(1);
      for (int p = 0; p < 2; p++) begin
         i_host.drive(1'b0, (p == 0) ? 4'h7 : 4'h1, 2'h0, 12'h000, 2'h0, ~hostDq);
         nop(1);
         check_val(32'(powerState), (p == 0) ? 32'(PWR_DOWN) : 32'(PWR_SELF_REFRESH));
         nop(1);
         check_val(32'(powerState), 32'(PWR_ACTIVE));
      end
      nop(10);
      check_val(32'(expQ.size()), 32'h0);
      check_val(32'({writeDrop, bufferReady}), 32'h1);
      completeRun();
   end
endmodule : tb_sdram_pin_protocol_and_power_up_init
